// file: design/fault_resp_regs.vh
`ifndef FAULT_RESP_REGS_VH
`define FAULT_RESP_REGS_VH
`define OC_ACTION_CODE      8'h47
`define TON_ACTION_CODE     8'hd0
`define RETRY_IVL_CODE      8'hd1
`define CLEAR_FAULTS_CODE   8'h03
`define OC_ACTION_RESET     8'h00
`define TON_ACTION_RESET    8'hb8
`define RETRY_IVL_RESET     8'h0a
`define RESP_HI             7
`define RESP_LO             6
`define RETRY_HI            5
`define RETRY_LO            3
`define DELAY_HI            2
`define DELAY_LO            0
`define RESP_IGNORE         2'b00
`define RESP_DELAYED        2'b10
`define RESP_OFF            2'b11
`define RETRY_NONE          3'b000
`define RETRY_FOREVER       3'b111
`define STEP_MS             16
`define CLK_MHZ             100
`define STEP_CYCLES         (`STEP_MS * 1000 * `CLK_MHZ)
`define RETRY_UNIT_MS       1
`define RETRY_UNIT_CYCLES   (`RETRY_UNIT_MS * 1000 * `CLK_MHZ)
`endif

// file: design/tick_gen.v
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
    parameter integer PERIOD = 1600000
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Tick
    output reg         tick
);
    reg [31:0] cnt_r;
    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (cnt_r >= PERIOD - 1) begin
            cnt_r <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule // tick_gen
`default_nettype wire

// file: design/sync3.v
`timescale 1ns/1ps
`default_nettype none
module sync3 (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Pin
    input  wire        din,
    output reg         dout
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    // Second and third must agree before a change counts
    always @(posedge clk_sys) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                dout <= s3_r;
        end
    end
endmodule // sync3
`default_nettype wire

// file: design/fault_response_control.v
`timescale 1ns/1ps
`default_nettype none
`include "fault_resp_regs.vh"
module fault_response_control #(
    parameter integer STEP_CYCLES  = `STEP_CYCLES,
    parameter integer RETRY_CYCLES = `RETRY_UNIT_CYCLES
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Command port
    input  wire        cmd_wr,
    input  wire        cmd_rd,
    input  wire [7:0]  cmd_code,
    input  wire [7:0]  cmd_wdata,
    output reg  [7:0]  cmd_rdata,
    output reg         cmd_ack,
    // Fault detectors and control
    input  wire        oc_detect,
    input  wire        ton_timeout,
    input  wire        other_hard_fault,
    input  wire        run_pin,
    input  wire        operation_on,
    // Output control
    output reg         output_enable,
    output reg         current_limit,
    output reg         alert_n,
    // Status
    output reg  [7:0]  status_byte,
    output reg  [15:0] status_word,
    output reg  [7:0]  status_vout,
    output reg  [7:0]  status_iout
);
    localparam [3:0] S_OFF   = 4'b0001;
    localparam [3:0] S_RUN   = 4'b0010;
    localparam [3:0] S_WAIT  = 4'b0100;
    localparam [3:0] S_LATCH = 4'b1000;

    function [7:0] ivl_read;
        input [7:0] code;
        input [7:0] oc;
        input [7:0] ton;
        input [7:0] ivl;
        begin
            case (code)
                `OC_ACTION_CODE:  ivl_read = oc;
                `TON_ACTION_CODE: ivl_read = ton;
                `RETRY_IVL_CODE:  ivl_read = ivl;
                default:          ivl_read = 8'h00;
            endcase
        end
    endfunction

    reg  [7:0]  oc_action_r;
    reg  [7:0]  ton_action_r;
    reg  [7:0]  retry_ivl_r;
    reg  [3:0]  state_r;
    reg  [3:0]  delay_r;
    reg         delay_on_r;
    reg  [7:0]  retry_cnt_r;
    reg  [2:0]  retry_sel_r;
    reg         oc_prev_r;
    reg         ton_prev_r;
    reg         on_prev_r;
    reg         oc_flag_r;
    reg         ton_flag_r;
    wire        run_s;
    wire        step_tick;
    wire        ms_tick;
    wire        on_cmd   = run_s & operation_on;
    wire        on_rise  = on_cmd & ~on_prev_r;
    wire        oc_new   = oc_detect & ~oc_prev_r;
    wire        ton_new  = ton_timeout & ~ton_prev_r;
    wire        clr_cmd  = cmd_wr && cmd_code == `CLEAR_FAULTS_CODE;
    wire [1:0]  oc_resp  = oc_action_r[`RESP_HI:`RESP_LO];
    wire        ton_act  = ton_new && ton_action_r != 8'h00;
    // prescaler restarts with each new delayed fault, so the first step is a full one
    wire        step_clr = rst | (state_r == S_RUN && oc_new && oc_resp == `RESP_DELAYED);
    // Retry prescaler held until waiting starts; keeps the restart gap exact
    wire        ms_clr   = rst | (state_r != S_WAIT);

    sync3 u_run_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (run_pin),
        .dout    (run_s)
    );
    tick_gen #(.PERIOD(STEP_CYCLES)) u_step (
        .clk_sys (clk_sys),
        .rst     (step_clr),
        .tick    (step_tick)
    );
    tick_gen #(.PERIOD(RETRY_CYCLES)) u_ms (
        .clk_sys (clk_sys),
        .rst     (ms_clr),
        .tick    (ms_tick)
    );

    // Register access
    always @(posedge clk_sys) begin
        if (rst) begin
            oc_action_r  <= `OC_ACTION_RESET;
            ton_action_r <= `TON_ACTION_RESET;
            retry_ivl_r  <= `RETRY_IVL_RESET;
            cmd_rdata    <= 8'h00;
            cmd_ack      <= 1'b0;
        end else begin
            cmd_ack <= cmd_wr | cmd_rd;
            if (cmd_wr) begin
                if (cmd_code == `OC_ACTION_CODE)
                    oc_action_r <= cmd_wdata;
                if (cmd_code == `TON_ACTION_CODE)
                    ton_action_r <= cmd_wdata;
                if (cmd_code == `RETRY_IVL_CODE)
                    retry_ivl_r <= cmd_wdata;
            end
            if (cmd_rd)
                cmd_rdata <= ivl_read(cmd_code, oc_action_r, ton_action_r, retry_ivl_r);
        end
    end

    // Sticky flags; new events win over clears
    always @(posedge clk_sys) begin
        if (rst) begin
            oc_flag_r  <= 1'b0;
            ton_flag_r <= 1'b0;
            oc_prev_r  <= 1'b0;
            ton_prev_r <= 1'b0;
            on_prev_r  <= 1'b0;
        end else begin
            oc_prev_r  <= oc_detect;
            ton_prev_r <= ton_timeout;
            on_prev_r  <= on_cmd;
            if (oc_new)
                oc_flag_r <= 1'b1;
            else if (clr_cmd || on_rise)
                oc_flag_r <= 1'b0;
            if (ton_act)
                ton_flag_r <= 1'b1;
            else if (clr_cmd || on_rise)
                ton_flag_r <= 1'b0;
        end
    end

    // Status and alert
    always @(posedge clk_sys) begin
        if (rst) begin
            status_byte <= 8'h00;
            status_word <= 16'h0000;
            status_vout <= 8'h00;
            status_iout <= 8'h00;
            alert_n     <= 1'b1;
        end else begin
            status_byte <= {3'b000, oc_flag_r, 3'b000, oc_flag_r | ton_flag_r};
            status_word <= {ton_flag_r, 1'b0, oc_flag_r, 5'b00000,
                            3'b000, oc_flag_r, 3'b000, oc_flag_r | ton_flag_r};
            status_vout <= {5'b00000, ton_flag_r, 2'b00};
            status_iout <= {oc_flag_r, 7'b000_0000};
            alert_n     <= ~(oc_flag_r | ton_flag_r);
        end
    end

    // Output state machine
    always @(posedge clk_sys) begin
        if (rst) begin
            state_r       <= S_OFF;
            delay_r       <= 4'h0;
            delay_on_r    <= 1'b0;
            retry_cnt_r   <= 8'h00;
            retry_sel_r   <= `RETRY_NONE;
            output_enable <= 1'b0;
            current_limit <= 1'b0;
        end else begin
            current_limit <= output_enable & oc_detect & (oc_resp != `RESP_OFF);
            case (state_r)
                S_OFF: begin
                    delay_on_r <= 1'b0;
                    if (on_rise) begin
                        state_r       <= S_RUN;
                        output_enable <= 1'b1;
                    end
                end
                S_RUN: begin
                    if (!on_cmd || other_hard_fault) begin
                        state_r       <= other_hard_fault ? S_LATCH : S_OFF;
                        output_enable <= 1'b0;
                        delay_on_r    <= 1'b0;
                    end else if (oc_new && oc_resp == `RESP_OFF) begin
                        output_enable <= 1'b0;
                        retry_sel_r   <= oc_action_r[`RETRY_HI:`RETRY_LO];
                        retry_cnt_r   <= retry_ivl_r;
                        state_r       <= (oc_action_r[`RETRY_HI:`RETRY_LO] == `RETRY_FOREVER) ? S_WAIT : S_LATCH;
                    end else if (oc_new && oc_resp == `RESP_DELAYED) begin
                        delay_r    <= {1'b0, oc_action_r[`DELAY_HI:`DELAY_LO]};
                        delay_on_r <= 1'b1;
                    end else if (delay_on_r && oc_resp == `RESP_DELAYED) begin
                        if (delay_r == 4'h0) begin
                            delay_on_r <= 1'b0;
                            if (oc_detect) begin
                                output_enable <= 1'b0;
                                retry_sel_r   <= oc_action_r[`RETRY_HI:`RETRY_LO];
                                retry_cnt_r   <= retry_ivl_r;
                                state_r       <= (oc_action_r[`RETRY_HI:`RETRY_LO] == `RETRY_FOREVER) ? S_WAIT : S_LATCH;
                            end
                        end else if (step_tick) begin
                            delay_r <= delay_r - 4'h1;
                        end
                    end else if (ton_act && ton_action_r[`RESP_HI:`RESP_LO] != `RESP_IGNORE) begin
                        output_enable <= 1'b0;
                        retry_sel_r   <= ton_action_r[`RETRY_HI:`RETRY_LO];
                        retry_cnt_r   <= retry_ivl_r;
                        state_r       <= (ton_action_r[`RETRY_HI:`RETRY_LO] == `RETRY_FOREVER) ? S_WAIT : S_LATCH;
                    end
                end
                S_WAIT: begin
                    if (!on_cmd) begin
                        state_r <= S_OFF;
                    end else if (other_hard_fault) begin
                        state_r <= S_LATCH;
                    end else if (retry_cnt_r == 8'h00) begin
                        state_r       <= S_RUN;
                        output_enable <= 1'b1;
                    end else if (ms_tick) begin
                        retry_cnt_r <= retry_cnt_r - 8'h01;
                    end
                end
                S_LATCH: begin
                    output_enable <= 1'b0;
                    if (!on_cmd)
                        state_r <= S_OFF;
                end
                default: begin
                    state_r       <= S_OFF;
                    output_enable <= 1'b0;
                end
            endcase
        end
    end
endmodule // fault_response_control
`default_nettype wire

// file: bench/fault_resp_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fault_resp_chk #(
    parameter integer STEP_CYCLES  = 20,
    parameter integer RETRY_CYCLES = 5
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Command port
    input wire logic        cmd_wr,
    input wire logic        cmd_rd,
    input wire logic [7:0]  cmd_code,
    input wire logic [7:0]  cmd_wdata,
    input wire logic        cmd_ack,
    // Faults and control
    input wire logic        oc_detect,
    input wire logic        ton_timeout,
    input wire logic        other_hard_fault,
    input wire logic        operation_on,
    // Outputs
    input wire logic        output_enable,
    input wire logic        alert_n,
    input wire logic [7:0]  status_byte,
    input wire logic [15:0] status_word,
    input wire logic [7:0]  status_vout,
    input wire logic [7:0]  status_iout
);
    logic [7:0]  oc_cfg_r;
    logic [15:0] oc_cnt_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Shadow of the action byte; loads on the same edge as the register, so checks leave slack
    always_ff @(posedge clk_sys) begin
        if (rst)
            oc_cfg_r <= 8'h00;
        else if (cmd_wr && cmd_code == 8'h47)
            oc_cfg_r <= cmd_wdata;
        if (rst || !oc_detect)
            oc_cnt_r <= 16'h0000;
        else if (oc_cnt_r != 16'hffff)
            oc_cnt_r <= oc_cnt_r + 16'h0001;
    end
    ack_follows_a: assert property ((cmd_wr || cmd_rd) |=> cmd_ack) else $error("no ack");
    ack_idle_a: assert property (!(cmd_wr || cmd_rd) |=> !cmd_ack) else $error("stray ack");
    oc_flags_a: assert property ($rose(oc_detect) |-> ##[1:2]
        (status_iout[7] && status_byte[4] && status_byte[0] && status_word[13])) else $error("oc flags");
    ton_flags_a: assert property ($rose(ton_timeout) |-> ##[1:2]
        (status_vout[2] && status_byte[0] && status_word[15])) else $error("timeout flags");
    fault_alert_a: assert property (($rose(oc_detect) || $rose(ton_timeout)) |-> ##[1:2] !alert_n)
        else $error("no alert");
    off_at_once_a: assert property ($rose(oc_detect) && oc_cfg_r[7:6] == 2'b11 |-> ##[1:2] !output_enable)
        else $error("late shutdown");
    ignore_runs_a: assert property (oc_detect && oc_cfg_r[7:6] == 2'b00 && output_enable && operation_on
        && !ton_timeout && !other_hard_fault |=> output_enable) else $error("ignored fault shut down");
    delay_min_a: assert property ($fell(output_enable) && oc_cfg_r[7:6] == 2'b10 && oc_detect
        |-> oc_cnt_r + 16'd2 >= oc_cfg_r[2:0] * STEP_CYCLES) else $error("delay too short");
    hard_fault_off_a: assert property ($rose(other_hard_fault) |-> ##[1:3] !output_enable)
        else $error("hard fault ignored");
    cover property ($fell(output_enable) && oc_cfg_r[7:6] == 2'b10);
    cover property ($rose(output_enable) && oc_cfg_r[5:3] == 3'b111);
    cover property ($rose(ton_timeout));
endmodule // fault_resp_chk
bind fault_response_control fault_resp_chk #(.STEP_CYCLES(STEP_CYCLES), .RETRY_CYCLES(RETRY_CYCLES)) i_chk (
    .clk_sys, .rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_ack, .oc_detect, .ton_timeout,
    .other_hard_fault, .operation_on, .output_enable, .alert_n, .status_byte, .status_word,
    .status_vout, .status_iout);
`default_nettype wire

// file: bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic       clk_sys,
    // Command port
    output logic            cmd_wr,
    output logic            cmd_rd,
    output logic [7:0]      cmd_code,
    output logic [7:0]      cmd_wdata,
    input  wire logic [7:0] cmd_rdata,
    input  wire logic       cmd_ack
);
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
    end
    task automatic xfer(input logic wr, input logic [7:0] c, input logic [7:0] d,
                        output logic [7:0] rdata, output logic ok);
        ok = 1'b0;
        if (wr && c == 8'hd0 && d == 8'h00)
            d = 8'hb8;
        @(posedge clk_sys);
        #1;
        cmd_wr = wr;
        cmd_rd = !wr;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge clk_sys);
        #1;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        // Released data shows a changed pattern, not the last byte
        cmd_wdata = ~d;
        for (int i = 0; i < 4 && !ok; i++) begin
            ok = (cmd_ack === 1'b1);
            if (!ok) begin
                @(posedge clk_sys);
                #1;
            end
        end
        rdata = cmd_rdata;
    endtask
endmodule // host_model
`default_nettype wire

// file: bench/fault_response_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fault_response_control_tb;
    localparam integer STEP = 20;
    localparam integer RIVL = 5;
    logic        clk_sys, rst, cmd_wr, cmd_rd, cmd_ack, oc_detect, ton_timeout, other_hard_fault;
    logic        run_pin, operation_on, output_enable, current_limit, alert_n, ok;
    logic [7:0]  cmd_code, cmd_wdata, cmd_rdata, status_byte, status_vout, status_iout, rv;
    logic [15:0] status_word;
    int          bad_count, checked, n;
    host_model i_host (.clk_sys, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_ack);
    fault_response_control #(.STEP_CYCLES(STEP), .RETRY_CYCLES(RIVL)) i_dut (
        .clk_sys, .rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_ack, .oc_detect,
        .ton_timeout, .other_hard_fault, .run_pin, .operation_on, .output_enable, .current_limit,
        .alert_n, .status_byte, .status_word, .status_vout, .status_iout);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic end_sim;
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        i_host.xfer(1'b1, c, d, rv, ok);
        chk("ack", 16'h0001, {15'h0000, ok});
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        i_host.xfer(1'b0, c, 8'h00, rv, ok);
        chk("rdata", {8'h00, e}, {7'h00, ok, rv} & 16'h01ff ^ 16'h0100);
    endtask
    // Bounded wait on the output switch; a lost bound ends the run
    task automatic wait_oe(input logic v, input int lim);
        n = 0;
        while (output_enable !== v && n < lim) begin
            tick(1);
            n++;
        end
        if (output_enable !== v) begin
            chk("output_enable", {15'h0000, v}, {15'h0000, output_enable});
            end_sim();
        end
    endtask
    task automatic s_regs;
        rd(8'h47, 8'h00);
        wr(8'h47, 8'hc5);
        rd(8'h47, 8'hc5);
        rd(8'h3e, 8'h00);
    endtask
    task automatic s_ignore;
        wr(8'h47, 8'h00);
        wait_oe(1'b1, 20);
        oc_detect = 1'b1;
        tick(30);
        chk("oe", 16'h0001, {15'h0000, output_enable});
        chk("limit", 16'h0001, {15'h0000, current_limit});
        chk("byte", 16'h0011, {8'h00, status_byte} & 16'h0011);
        chk("word", 16'h2000, status_word & 16'h2000);
        chk("iout", 16'h0080, {8'h00, status_iout} & 16'h0080);
        chk("alert_n", 16'h0000, {15'h0000, alert_n});
        oc_detect = 1'b0;
        tick(20);
        chk("iout held", 16'h0080, {8'h00, status_iout} & 16'h0080);
        wr(8'h03, 8'h00);
        tick(3);
        chk("byte clr", 16'h0000, {8'h00, status_byte});
        chk("alert clr", 16'h0001, {15'h0000, alert_n});
    endtask
    task automatic s_delayed;
        wr(8'h47, 8'h82);
        oc_detect = 1'b1;
        tick(STEP);
        oc_detect = 1'b0;
        tick(3 * STEP);
        chk("oe short", 16'h0001, {15'h0000, output_enable});
        oc_detect = 1'b1;
        wait_oe(1'b0, 8 * STEP);
        chk("delay", 16'h0001, {15'h0000, n >= 2 * STEP - 2 && n <= 2 * STEP + 3});
        oc_detect = 1'b0;
        tick(100);
        chk("latched", 16'h0000, {15'h0000, output_enable});
        wr(8'h03, 8'h00);
        tick(5);
        chk("clr keeps off", 16'h0000, {15'h0000, output_enable});
        operation_on = 1'b0;
        tick(3);
        operation_on = 1'b1;
        wait_oe(1'b1, 20);
        wr(8'h47, 8'hc0);
        oc_detect = 1'b1;
        tick(2);
        chk("oe at once", 16'h0000, {15'h0000, output_enable});
        oc_detect = 1'b0;
        run_pin = 1'b0;
        tick(10);
        run_pin = 1'b1;
        wait_oe(1'b1, 30);
        tick(2);
        chk("iout cycled", 16'h0000, {8'h00, status_iout});
    endtask
    task automatic s_retry;
        wr(8'h47, 8'hf8);
        oc_detect = 1'b1;
        tick(2);
        oc_detect = 1'b0;
        chk("oe trip", 16'h0000, {15'h0000, output_enable});
        wait_oe(1'b1, 300);
        chk("retry gap", 16'h0001, {15'h0000, n >= 10 * RIVL - 3 && n <= 10 * RIVL + 5});
    endtask
    task automatic s_timeout;
        wr(8'h47, 8'h00);
        wr(8'h03, 8'h00);
        ton_timeout = 1'b1;
        tick(3);
        ton_timeout = 1'b0;
        chk("vout", 16'h0004, {8'h00, status_vout} & 16'h0004);
        chk("word ton", 16'h8001, status_word & 16'h8001);
        chk("alert ton", 16'h0000, {15'h0000, alert_n});
        other_hard_fault = 1'b1;
        tick(3);
        other_hard_fault = 1'b0;
        tick(150);
        chk("no restart", 16'h0000, {15'h0000, output_enable});
    endtask
    initial begin
        {rst, oc_detect, ton_timeout, other_hard_fault} = 4'b1000;
        {run_pin, operation_on} = 2'b11;
        bad_count = 0;
        checked = 0;
        tick(5);
        rst = 1'b0;
        s_regs();
        s_ignore();
        s_delayed();
        s_retry();
        s_timeout();
        end_sim();
    end
endmodule // fault_response_control_tb
`default_nettype wire
